// ==== hdl/psc_regs.svh ====
// timing constants for the select and reset controller
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

`define PSC_CLK_MHZ 125
`define PSC_RST_STD_NS 100
`define PSC_RST_LV_NS 500
`define PSC_RECOVER_LV_NS 500
`define PSC_NS_TO_CYC(ns) (((ns) * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_RST_STD_CYC `PSC_NS_TO_CYC(`PSC_RST_STD_NS)
`define PSC_RST_LV_CYC `PSC_NS_TO_CYC(`PSC_RST_LV_NS)
`define PSC_RECOVER_LV_CYC `PSC_NS_TO_CYC(`PSC_RECOVER_LV_NS)
`define PSC_TIMER_W 8

`endif

// ==== hdl/psc_pkg.sv ====
// types for the select and reset controller
`include "psc_regs.svh"

package psc_pkg;
  typedef enum logic [1:0] {
    PSC_ASSERT,
    PSC_RECOVER,
    PSC_READY
  } psc_state_t;

  typedef struct packed {
    psc_state_t state;
    logic start;
    logic reset_pin;
    logic select_pin;
    logic ready;
    logic powered_down;
  } psc_ctrl_t;

  typedef struct packed {
    logic [`PSC_TIMER_W-1:0] count;
  } psc_timer_st_t;
endpackage

// ==== hdl/psc_timer_if.sv ====
// load and done handshake between controller and its timer
interface psc_timer_if #(parameter int W = 8);
  logic load;
  logic [W-1:0] value;
  logic done;
  modport ctrl (output load, output value, input done);
  modport timer (input load, input value, output done);
endinterface

// ==== hdl/psc_timer.sv ====
// down counter that times reset pulse width and recovery
module psc_timer
  import psc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  psc_timer_if.timer tif
);
  psc_timer_st_t st;
  psc_timer_st_t next_st;

  always_comb begin
    next_st = st;
    if (reset) begin
      next_st.count = '0;
    end else if (tif.load) begin
      next_st.count = tif.value;
    end else if (st.count != '0) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  assign tif.done = (st.count == '0);
endmodule

// ==== hdl/psc_top.sv ====
// host controller driving the peripheral's select and reset pins
// Summary of operation
// - standard part: hold reset at least 100ns
// - low-voltage: 500ns pulse, 500ns recovery
// - low-voltage reset is always active low
// - no access before device leaves reset
// - drive device reset actively, not by RC
`include "psc_regs.svh"

module psc_top
  import psc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic reset_request,
  input wire logic low_voltage_part,
  input wire logic reset_active_high,
  input wire logic select_mode_decoder,
  input wire logic power_down_request,
  input wire logic extra_decoder_input,
  output logic device_reset_pin,
  output logic multipurpose_select_pin,
  output logic device_ready,
  output logic device_powered_down
);
  localparam logic [`PSC_TIMER_W-1:0] RST_STD =
    `PSC_TIMER_W'(`PSC_RST_STD_CYC);
  localparam logic [`PSC_TIMER_W-1:0] RST_LV =
    `PSC_TIMER_W'(`PSC_RST_LV_CYC);
  localparam logic [`PSC_TIMER_W-1:0] REC_LV =
    `PSC_TIMER_W'(`PSC_RECOVER_LV_CYC);
  localparam int STD_CYC = `PSC_RST_STD_CYC;
  localparam int LV_CYC = `PSC_RST_LV_CYC;

  psc_ctrl_t st;
  psc_ctrl_t next_st;
  logic active_high;
  logic next_pd;

  psc_timer_if #(.W(`PSC_TIMER_W)) tif ();

  psc_timer u_timer (
    .core_clk(core_clk),
    .reset(reset),
    .tif(tif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control sequence

  // low-voltage parts only accept an active-low reset
  assign active_high = reset_active_high & ~low_voltage_part;

  always_comb begin
    next_st = st;
    tif.load = 1'b0;
    tif.value = low_voltage_part ? RST_LV : RST_STD;
    next_pd = ~select_mode_decoder & power_down_request;
    if (reset) begin
      next_st.state = PSC_ASSERT;
      next_st.start = 1'b1;
      next_st.ready = 1'b0;
      next_st.powered_down = 1'b0;
      next_st.select_pin = 1'b0;
    end else begin
      unique case (st.state)
        PSC_ASSERT: begin
          if (st.start) begin
            tif.load = 1'b1;
            next_st.start = 1'b0;
          end else if (tif.done) begin
            if (low_voltage_part) begin
              tif.load = 1'b1;
              tif.value = REC_LV;
              next_st.state = PSC_RECOVER;
            end else begin
              next_st.state = PSC_READY;
            end
          end
        end
        PSC_RECOVER: begin
          if (tif.done) begin
            next_st.state = PSC_READY;
          end
        end
        PSC_READY: begin
          if (reset_request) begin
            next_st.state = PSC_ASSERT;
            next_st.start = 1'b1;
          end
        end
      endcase
      next_st.select_pin = select_mode_decoder ? extra_decoder_input
                                               : power_down_request;
      next_st.powered_down = next_pd;
      // access allowed only once the device is out of reset and awake
      next_st.ready = (next_st.state == PSC_READY) & ~next_pd;
    end
    // pin is always driven to a full logic level
    next_st.reset_pin = (next_st.state == PSC_ASSERT) ~^ active_high;
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  assign device_reset_pin = st.reset_pin;
  assign multipurpose_select_pin = st.select_pin;
  assign device_ready = st.ready;
  assign device_powered_down = st.powered_down;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic asserted;
  logic [7:0] held_cycles;
  logic [7:0] free_cycles;
  logic lv_q;

  assign asserted = (st.state == PSC_ASSERT);

  always_ff @(posedge core_clk) begin
    lv_q <= low_voltage_part;
    if (reset || !asserted) begin
      held_cycles <= 8'h00;
    end else if (held_cycles != 8'hff) begin
      held_cycles <= held_cycles + 8'h01;
    end
    if (reset || asserted) begin
      free_cycles <= 8'h00;
    end else if (free_cycles != 8'hff) begin
      free_cycles <= free_cycles + 8'h01;
    end
  end

  chk_std_width: assert property (
    @(posedge core_clk) disable iff (reset)
    $fell(asserted) && !lv_q |-> int'($past(held_cycles)) >= STD_CYC)
    else $error("reset pulse shorter than standard minimum");

  chk_lv_width: assert property (
    @(posedge core_clk) disable iff (reset)
    $fell(asserted) && lv_q |-> int'($past(held_cycles)) >= LV_CYC)
    else $error("reset pulse shorter than low-voltage minimum");

  chk_lv_recovery: assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(device_ready) && lv_q |-> int'(free_cycles) >= LV_CYC)
    else $error("ready raised before low-voltage recovery");

  chk_lv_polarity: assert property (
    @(posedge core_clk) disable iff (reset)
    low_voltage_part && $stable(low_voltage_part) |=>
      device_reset_pin == !asserted)
    else $error("low-voltage reset not active low");

  chk_ready_gate: assert property (
    @(posedge core_clk) disable iff (reset)
    device_ready |-> !asserted && !device_powered_down)
    else $error("ready shown while device in reset or down");

  chk_pin_polarity: assert property (
    @(posedge core_clk) disable iff (reset)
    !low_voltage_part && reset_active_high && $stable(reset_active_high)
      |=> device_reset_pin == asserted)
    else $error("reset pin level does not follow sequence");

  chk_select_follow: assert property (
    @(posedge core_clk) disable iff (reset)
    !select_mode_decoder |=> multipurpose_select_pin ==
      $past(power_down_request))
    else $error("select pin does not follow power-down request");

  ////////////////////////////////////////////////////////////////////////////
  // sequence timing and mode checks

  chk_low_polarity: assert property (
    @(posedge core_clk) disable iff (reset)
    !low_voltage_part && !reset_active_high && $stable(reset_active_high)
      |=> device_reset_pin == !asserted)
    else $error("active-low reset pin level wrong");

  chk_std_release: assert property (
    @(posedge core_clk) disable iff (reset)
    $fell(asserted) && !lv_q |-> device_ready || device_powered_down)
    else $error("standard part not usable on reset release");

  chk_std_pulse_max: assert property (
    @(posedge core_clk) disable iff (reset)
    asserted && !lv_q |-> held_cycles <= 8'h10)
    else $error("standard reset pulse held too long");

  chk_pulse_bound: assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(asserted) |-> ##[1:70] !asserted)
    else $error("reset pulse never released");

  chk_lv_release: assert property (
    @(posedge core_clk) disable iff (reset)
    $fell(asserted) && lv_q |->
      ##64 (device_ready || device_powered_down))
    else $error("low-voltage recovery time wrong");

  chk_recover_quiet: assert property (
    @(posedge core_clk) disable iff (reset)
    st.state == PSC_RECOVER |-> !device_ready)
    else $error("ready shown during low-voltage recovery");

  chk_request_taken: assert property (
    @(posedge core_clk) disable iff (reset)
    st.state == PSC_READY && reset_request |=> asserted && !device_ready)
    else $error("reset request not taken in ready state");

  chk_down_follow: assert property (
    @(posedge core_clk) disable iff (reset)
    !select_mode_decoder |=> device_powered_down == $past(power_down_request))
    else $error("power-down flag does not follow request");

  chk_decoder_follow: assert property (
    @(posedge core_clk) disable iff (reset)
    select_mode_decoder |=> multipurpose_select_pin ==
      $past(extra_decoder_input))
    else $error("select pin does not carry decoder input");

  chk_decoder_awake: assert property (
    @(posedge core_clk) disable iff (reset)
    select_mode_decoder |=> !device_powered_down)
    else $error("device shown down in decoder mode");
endmodule

// ==== verif/psc_dev_model.sv ====
// behavioural model of the peripheral's select and reset pins
module psc_dev_model (
  input wire logic reset_pin,
  input wire logic active_high,
  input wire logic low_voltage,
  input wire logic select_pin,
  input wire logic decoder_mode,
  output logic usable,
  output logic powered_down
);
  timeunit 1ns;
  timeprecision 1ps;
  realtime t_on = 0.0;
  logic ok;
  wire logic rst_on = (active_high && !low_voltage) ? reset_pin : !reset_pin;
  ////////////////////////////////////////////////////////////////////////////
  initial usable = 1'b0;
  // pulse too short leaves the part unusable
  always @(rst_on) begin
    if (rst_on) begin
      t_on = $realtime;
      usable = 1'b0;
    end else begin
      ok = ($realtime - t_on) >= (low_voltage ? 500.0 : 100.0);
      if (low_voltage) #500;
      usable = ok && !rst_on;
    end
  end
  // registers kept, selects idle while powered down
  assign powered_down = !decoder_mode && select_pin;
endmodule

// ==== verif/tb_select_powerdown_reset_control.sv ====
// self-checking bench for the select and reset controller
module tb_select_powerdown_reset_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset = 1, reset_request = 0, low_voltage_part = 0;
  logic reset_active_high = 0, select_mode_decoder = 0;
  logic power_down_request = 0, extra_decoder_input = 0;
  logic device_reset_pin, multipurpose_select_pin, device_ready;
  logic device_powered_down, usable, model_pd, e, v, pv;
  logic exp_q[$];
  int errors = 0, total_checks = 0, seed = 57;
  always #4 core_clk = ~core_clk;
  psc_top dut (.core_clk(core_clk), .reset(reset),
    .reset_request(reset_request), .low_voltage_part(low_voltage_part),
    .reset_active_high(reset_active_high),
    .select_mode_decoder(select_mode_decoder),
    .power_down_request(power_down_request),
    .extra_decoder_input(extra_decoder_input),
    .device_reset_pin(device_reset_pin),
    .multipurpose_select_pin(multipurpose_select_pin),
    .device_ready(device_ready), .device_powered_down(device_powered_down));
  psc_dev_model model (.reset_pin(device_reset_pin),
    .active_high(reset_active_high), .low_voltage(low_voltage_part),
    .select_pin(multipurpose_select_pin), .decoder_mode(select_mode_decoder),
    .usable(usable), .powered_down(model_pd));
  ////////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task wait_ready;
    for (int i = 0; i < 400 && device_ready !== 1'b1; i++) @(negedge core_clk);
    if (device_ready !== 1'b1) begin
      check("ready_wait", 1'b1, device_ready);
      end_of_test();
    end else begin
      @(posedge core_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // each ready rise: pin released to idle level, part already usable
  always @(posedge device_ready) begin
    #1;
    e = exp_q.size() > 0 ? exp_q.pop_front() : 1'bx;
    check("idle_reset_pin", e, device_reset_pin);
    check("part_usable", 1'b1, usable);
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // active-high std, active-low std, low-voltage
    for (int c = 0; c < 3; c++) begin
      @(posedge core_clk);
      reset <= 1;
      low_voltage_part <= (c == 2);
      reset_active_high <= (c != 1);
      repeat (20) @(posedge core_clk);
      reset <= 0;
      exp_q.push_back(c != 0);
      wait_ready();
      @(posedge core_clk);
      reset_request <= 1;
      exp_q.push_back(c != 0);
      @(posedge core_clk);
      reset_request <= 0;
      @(negedge core_clk);
      check("ready_drop", 1'b0, device_ready);
      check("pin_asserted", c == 0, device_reset_pin);
      wait_ready();
    end
    @(posedge core_clk);
    power_down_request <= 1;
    @(posedge core_clk);
    @(negedge core_clk);
    check("select_high", 1'b1, multipurpose_select_pin);
    check("powered_down", 1'b1, device_powered_down);
    check("model_down", 1'b1, model_pd);
    check("ready_low", 1'b0, device_ready);
    @(posedge core_clk);
    power_down_request <= 0;
    exp_q.push_back(1'b1);
    wait_ready();
    select_mode_decoder <= 1;
    v = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      pv = v;
      v = $random(seed);
      extra_decoder_input <= v;
      power_down_request <= $random(seed);
      @(negedge core_clk);
      if (i > 1) check("decoder_pin", pv, multipurpose_select_pin);
      if (i > 1) check("never_down", 1'b0, device_powered_down);
    end
    end_of_test();
  end
endmodule
